// ---- hdl/pmsmc_pkg.sv ----
/*
 * Package for the power-management status, mask and control registers:
 * register indices, field positions, reset values and state encodings.
 * Assumes a byte-wide register port addressed by the serial bus front end.
 */
package pmsmc_pkg;
    // =====================================================================
    // Register indices
    localparam logic [7:0] ADDR_LS_MASK = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h05;
    localparam logic [7:0] ADDR_CONTROL = 8'h06;
    // =====================================================================
    // Field positions
    localparam int MASK_THERM_LSB = 3;
    localparam int MASK_OVCUR_LSB = 0;
    localparam logic [7:0] MASK_WR_BITS = 8'h3f;
    localparam int ST_SEAL = 7;
    localparam int ST_NVM = 6;
    localparam int ST_SUPPLY = 5;
    localparam int ST_BUTTON = 4;
    localparam int ST_STATE_LSB = 2;
    localparam int ST_COIN_LSB = 0;
    localparam int CTL_PF_EN = 1;
    localparam int CTL_MEASURE = 0;
    // =====================================================================
    // Reset values
    localparam logic [5:0] MASK_RESET = 6'h00;
    localparam logic PF_EN_RESET = 1'b0;
    localparam logic [1:0] COIN_RESET = 2'h0;
    // =====================================================================
    // Power state machine report encoding
    localparam logic [1:0] PS_TRANSITION = 2'h0;
    localparam logic [1:0] PS_AWAITING_POWER_ENABLE = 2'h1;
    localparam logic [1:0] PS_ACTIVE = 2'h2;
    localparam logic [1:0] PS_SUSPEND = 2'h3;
    typedef enum logic [1:0] {
        PMSMC_MEAS_IDLE,
        PMSMC_MEAS_BUSY
    } pmsmc_meas_t;
endpackage : pmsmc_pkg

// ---- hdl/pmsmc_regs.sv ----
/*
 * Register block: load-switch interrupt mask, live device status and
 * power-fail / coin-cell measurement control, plus interrupt pin drive.
 * Assumes a decoded byte register port from the serial bus slave and
 * event, state and measurement inputs synchronous to clk.
 */
// Summary of operation
// - A clear mask bit lets its event pull the pin low, set hides it.
// - Masking never stops event detection or the flags.
// - Mask bits 5..3 hide switch 3..1 thermal faults; 7-6 read zero.
// - Mask bits 2..0 hide switch 3..1 current limits; all reset to 0.
// - Status bit 7 reads 1 once the freshness seal is broken, else 0.
// - Status bit 6 reads 1 when stored defaults differ from factory.
// - Status bit 5 reads 1 while the supply-detect pin is low.
// - Status bit 4 reads 1 while the push-button pin is low.
// - Status bits 3-2 report the power state machine state code.
// - Status bits 1-0 report the coin-cell level code.
// - Control bit 1 set and a low power-fail output request shutdown.
// - Writing 1 to control bit 0 starts a measurement; it self-clears.
// - A current-limit flag is 1 only while its switch is limiting.
module pmsmc_regs #(
    parameter int NUM_SWITCH = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [NUM_SWITCH-1:0] switch_thermal_flag,
    input wire logic [NUM_SWITCH-1:0] switch_current_limit,
    input wire logic [NUM_SWITCH-1:0] switch_enabled,
    input wire logic factory_seal_broken,
    input wire logic nvm_changed_flag,
    input wire logic supply_detect_input_n,
    input wire logic push_button_input_n,
    input wire logic [1:0] power_state,
    input wire logic power_fail_output_n,
    input wire logic measure_done,
    input wire logic [1:0] measured_coin_level,
    output logic interrupt_request_pin_n,
    output logic measure_start,
    output logic shutdown_request,
    output logic [NUM_SWITCH-1:0] switch_overcurrent_flag
);
    // =====================================================================
    // Registers
    logic [NUM_SWITCH-1:0] therm_mask_q;
    logic [NUM_SWITCH-1:0] ovcur_mask_q;
    logic pf_en_q;
    logic measure_q;
    logic [1:0] coin_level_q;
    logic [7:0] status_d;
    logic [7:0] rdata_d;
    logic pending_d;
    pmsmc_pkg::pmsmc_meas_t meas_q;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction : hit

    // =====================================================================
    // Mask register
    // mask write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            therm_mask_q <= NUM_SWITCH'(pmsmc_pkg::MASK_RESET);
            ovcur_mask_q <= NUM_SWITCH'(pmsmc_pkg::MASK_RESET);
        end else if (reg_wr && hit(reg_addr, pmsmc_pkg::ADDR_LS_MASK)) begin
            therm_mask_q <= reg_wdata[pmsmc_pkg::MASK_THERM_LSB +: NUM_SWITCH];
            ovcur_mask_q <= reg_wdata[pmsmc_pkg::MASK_OVCUR_LSB +: NUM_SWITCH];
        end
    end

    // =====================================================================
    // Control register; trigger self-clears after one cycle
    // self-clearing trigger
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pf_en_q <= pmsmc_pkg::PF_EN_RESET;
            measure_q <= 1'b0;
        end else begin
            measure_q <= reg_wr && hit(reg_addr, pmsmc_pkg::ADDR_CONTROL)
                && reg_wdata[pmsmc_pkg::CTL_MEASURE];
            if (reg_wr && hit(reg_addr, pmsmc_pkg::ADDR_CONTROL)) begin
                pf_en_q <= reg_wdata[pmsmc_pkg::CTL_PF_EN];
            end
        end
    end

    // Measurement tracking; level latched only when a result arrives
    // coin level capture
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meas_q <= pmsmc_pkg::PMSMC_MEAS_IDLE;
            coin_level_q <= pmsmc_pkg::COIN_RESET;
            measure_start <= 1'b0;
        end else begin
            measure_start <= measure_q;
            case (meas_q)
                pmsmc_pkg::PMSMC_MEAS_IDLE: begin
                    if (measure_q) begin
                        meas_q <= pmsmc_pkg::PMSMC_MEAS_BUSY;
                    end
                end
                pmsmc_pkg::PMSMC_MEAS_BUSY: begin
                    if (measure_done) begin
                        coin_level_q <= measured_coin_level;
                        meas_q <= pmsmc_pkg::PMSMC_MEAS_IDLE;
                    end
                end
                default: meas_q <= pmsmc_pkg::PMSMC_MEAS_IDLE;
            endcase
        end
    end

    // =====================================================================
    // Power-fail shutdown
    // power-fail shutdown
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shutdown_request <= 1'b0;
        end else begin
            shutdown_request <= pf_en_q && !power_fail_output_n;
        end
    end

    // =====================================================================
    // Flags follow hardware regardless of masks
    // live current-limit flag
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            switch_overcurrent_flag <= '0;
        end else begin
            switch_overcurrent_flag <= switch_current_limit & switch_enabled;
        end
    end

    always_comb begin
        pending_d = |(switch_thermal_flag & ~therm_mask_q)
            | |(switch_current_limit & switch_enabled & ~ovcur_mask_q);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            interrupt_request_pin_n <= 1'b1;
        end else begin
            interrupt_request_pin_n <= !pending_d;
        end
    end

    // =====================================================================
    // Read path
    // status assembly
    always_comb begin
        status_d = 8'h00;
        status_d[pmsmc_pkg::ST_SEAL] = factory_seal_broken;
        status_d[pmsmc_pkg::ST_NVM] = nvm_changed_flag;
        status_d[pmsmc_pkg::ST_SUPPLY] = !supply_detect_input_n;
        status_d[pmsmc_pkg::ST_BUTTON] = !push_button_input_n;
        status_d[pmsmc_pkg::ST_STATE_LSB +: 2] = power_state;
        status_d[pmsmc_pkg::ST_COIN_LSB +: 2] = coin_level_q;
    end

    always_comb begin
        rdata_d = 8'h00;
        if (hit(reg_addr, pmsmc_pkg::ADDR_LS_MASK)) begin
            rdata_d[pmsmc_pkg::MASK_THERM_LSB +: NUM_SWITCH] = therm_mask_q;
            rdata_d[pmsmc_pkg::MASK_OVCUR_LSB +: NUM_SWITCH] = ovcur_mask_q;
        end else if (hit(reg_addr, pmsmc_pkg::ADDR_STATUS)) begin
            rdata_d = status_d;
        end else if (hit(reg_addr, pmsmc_pkg::ADDR_CONTROL)) begin
            rdata_d[pmsmc_pkg::CTL_PF_EN] = pf_en_q;
            rdata_d[pmsmc_pkg::CTL_MEASURE] = measure_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end
    end

    // =====================================================================
    // Checks
    // pin follows unmasked events
    int_pin_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        ##1 (interrupt_request_pin_n == !$past(pending_d)))
        else $error("interrupt pin disagrees with pending events");
    mask_reset_a: assert property (
        @(posedge clk)
        !rst_n |=> (therm_mask_q == '0 && ovcur_mask_q == '0))
        else $error("masks not cleared by reset");
    trig_clear_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        measure_q |=> !measure_q || $past(reg_wr))
        else $error("measure trigger did not self clear");
    meas_start_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (reg_wr && reg_addr == pmsmc_pkg::ADDR_CONTROL
        && reg_wdata[pmsmc_pkg::CTL_MEASURE]) |=> ##1 measure_start)
        else $error("measurement not started two cycles after trigger");
    pf_shutdown_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        shutdown_request |-> $past(pf_en_q) && !$past(power_fail_output_n))
        else $error("shutdown without enable and power fail");
    ovcur_flag_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        $past(!switch_enabled[0]) |-> !switch_overcurrent_flag[0])
        else $error("current-limit flag set on disabled switch");
    live_status_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (reg_rd && reg_addr == pmsmc_pkg::ADDR_STATUS) |=>
        reg_rdata[5:4] == ~$past({supply_detect_input_n,
        push_button_input_n}))
        else $error("status inputs not reported live");
    reserved_zero_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        (reg_rd && reg_addr == pmsmc_pkg::ADDR_CONTROL) |=>
        reg_rdata[7:2] == 6'h00)
        else $error("reserved control bits not zero");
    shutdown_c: cover property (@(posedge clk) shutdown_request);
    int_c: cover property (@(posedge clk) !interrupt_request_pin_n);
    meas_c: cover property (@(posedge clk)
        meas_q == pmsmc_pkg::PMSMC_MEAS_BUSY ##1 measure_done);
endmodule : pmsmc_regs

// ---- testbench/pmsmc_host.sv ----
/*
 * Host model: byte register accesses on the decoded register port.
 * Assumes strobes are sampled on rising clk; it drives on falling edges.
 */
module pmsmc_host (
    input wire logic clk,
    input wire logic [7:0] reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // =====================================================================
    // Access tasks
    // Idle bus shows the inverse so stale values are never trusted
    // host register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        @(negedge clk);
        d = reg_rdata;
    endtask : rd
endmodule : pmsmc_host

// ---- testbench/pmsmc_regs_tb.sv ----
/*
 * Bench for the status, mask and control registers.
 * Assumes the host model for bus cycles; other inputs change at negedge.
 */
module pmsmc_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, wr, rd, seal, nvm, sup_n, btn_n, pfo_n, mdone;
    logic int_n, mstart, shut;
    logic [7:0] addr, wdata, rdata, v, e;
    logic [2:0] thermal, limit, en, ovf;
    logic [1:0] pstate, mlevel;
    int err_count = 0;
    int comparisons = 0;
    int n;
    pmsmc_regs i_pmsmc_regs (.clk(clk), .rst_n(rst_n), .reg_wr(wr),
        .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
        .switch_thermal_flag(thermal), .switch_current_limit(limit),
        .switch_enabled(en), .factory_seal_broken(seal),
        .nvm_changed_flag(nvm), .supply_detect_input_n(sup_n),
        .push_button_input_n(btn_n), .power_state(pstate),
        .power_fail_output_n(pfo_n), .measure_done(mdone),
        .measured_coin_level(mlevel), .interrupt_request_pin_n(int_n),
        .measure_start(mstart), .shutdown_request(shut),
        .switch_overcurrent_flag(ovf));
    pmsmc_host i_pmsmc_host (.clk(clk), .reg_rdata(rdata), .reg_wr(wr),
        .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // =====================================================================
    // Checking and verdict
    task automatic chk(input string s, input logic [7:0] a,
                       input logic [7:0] e);
        comparisons++;
        if (a !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", s, e, a);
        end
    endtask : chk
    task automatic results();
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results
    // Events 0..2 are current limits, 3..5 thermal faults
    task automatic ev(input int k, input logic b);
        if (k < 3) limit[k] = b;
        else thermal[k-3] = b;
    endtask : ev
    // Run takes under two hundred cycles; this is ample margin
    initial begin
        #20000;
        err_count++;
        results();
    end
    // =====================================================================
    // Test sequence
    initial begin
        {thermal, limit, en, seal, nvm, pstate, mlevel, mdone} = '0;
        {sup_n, btn_n, pfo_n} = 3'h7;
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        i_pmsmc_host.rd(pmsmc_pkg::ADDR_LS_MASK, v);
        chk("mask reset", v, 8'h00);
        chk("pin idle", {7'h00, int_n}, 8'h01);
        i_pmsmc_host.wr(pmsmc_pkg::ADDR_LS_MASK, 8'hff);
        i_pmsmc_host.rd(pmsmc_pkg::ADDR_LS_MASK, v);
        chk("mask rsv", v, 8'h3f);
        i_pmsmc_host.wr(pmsmc_pkg::ADDR_CONTROL, 8'hfc);
        i_pmsmc_host.rd(pmsmc_pkg::ADDR_CONTROL, v);
        chk("ctrl rsv", v, 8'h00);
        i_pmsmc_host.wr(8'h07, 8'hff);
        i_pmsmc_host.rd(8'h07, v);
        chk("unmapped", v, 8'h00);
        for (int i = 0; i < 4; i++) begin
            {seal, nvm, sup_n, btn_n} = {i[0], i[1], i[0], ~i[1]};
            pstate = i[1:0];
            i_pmsmc_host.wr(pmsmc_pkg::ADDR_STATUS, 8'hff);
            i_pmsmc_host.rd(pmsmc_pkg::ADDR_STATUS, v);
            e = {i[0], i[1], ~i[0], i[1], i[1:0], 2'h0};
            chk("status", v, e);
        end
        i_pmsmc_host.wr(pmsmc_pkg::ADDR_LS_MASK, 8'h00);
        en = 3'h7;
        for (int k = 0; k < 6; k++) begin
            ev(k, 1'b1);
            repeat (3) @(negedge clk);
            chk("pin open", {7'h00, int_n}, 8'h00);
            i_pmsmc_host.wr(pmsmc_pkg::ADDR_LS_MASK, 8'h01 << k);
            repeat (2) @(negedge clk);
            chk("pin masked", {7'h00, int_n}, 8'h01);
            chk("flag kept", {5'h00, ovf}, {5'h00, limit});
            ev(k, 1'b0);
            i_pmsmc_host.wr(pmsmc_pkg::ADDR_LS_MASK, 8'h00);
            repeat (2) @(negedge clk);
            chk("pin release", {7'h00, int_n}, 8'h01);
        end
        {en, limit} = 6'h07;
        repeat (3) @(negedge clk);
        chk("limit off", {5'h00, ovf}, 8'h00);
        chk("pin off", {7'h00, int_n}, 8'h01);
        limit = 3'h0;
        pfo_n = 1'b0;
        repeat (3) @(negedge clk);
        chk("no shutdown", {7'h00, shut}, 8'h00);
        i_pmsmc_host.wr(pmsmc_pkg::ADDR_CONTROL, 8'h02);
        repeat (2) @(negedge clk);
        chk("shutdown", {7'h00, shut}, 8'h01);
        for (int c = 0; c < 4; c++) begin
            n = 0;
            i_pmsmc_host.wr(pmsmc_pkg::ADDR_CONTROL, 8'h03);
            repeat (4) begin
                @(negedge clk);
                n += int'(mstart);
            end
            chk("start pulse", n[7:0], 8'h01);
            i_pmsmc_host.rd(pmsmc_pkg::ADDR_CONTROL, v);
            chk("self clear", v, 8'h02);
            {mlevel, mdone} = {c[1:0], 1'b1};
            @(negedge clk);
            mdone = 1'b0;
            i_pmsmc_host.rd(pmsmc_pkg::ADDR_STATUS, v);
            chk("coin", {6'h00, v[1:0]}, {6'h00, c[1:0]});
        end
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        chk("shut reset", {7'h00, shut}, 8'h00);
        i_pmsmc_host.rd(pmsmc_pkg::ADDR_CONTROL, v);
        chk("ctrl reset", v, 8'h00);
        results();
    end
endmodule : pmsmc_regs_tb
